// [src/prga_cfg.svh]
// Register offsets, field positions, reset values and pin codes of the rotating group arbiter
`ifndef PRGA_CFG_SVH
`define PRGA_CFG_SVH

// APB word offsets
`define PRGA_ADDR_W        12
`define PRGA_OFS_CTRL_LO   12'h000
`define PRGA_OFS_CTRL_HI   12'h004
`define PRGA_OFS_STATUS    12'h008

// Field positions within the 64-bit bus_arbitration_control view
`define PRGA_F_TIER_A      0
`define PRGA_F_TIER_B      8
`define PRGA_F_TIER_C      16
`define PRGA_F_RUN_A       24
`define PRGA_F_RUN_ON      28
`define PRGA_F_RUN_B       32
`define PRGA_F_RUN_C       36
`define PRGA_F_HOLD_A      40
`define PRGA_F_HOLD_B      44
`define PRGA_F_HOLD_C      48
`define PRGA_F_IDLE_SEL    52
`define PRGA_F_DISABLE     63

// Reset value and writable bits; reserved bits are held at zero
`define PRGA_CTRL_RESET    64'h0050_0011_1100_003F
`define PRGA_CTRL_WMASK    64'h807F_FFFF_FF3F_3F3F

// Requestor codes
`define PRGA_SEL_OWN       3'h5
`define PRGA_SEL_NONE      3'h7

// Pin synchroniser width: reqN[4:0], frameN, irdyN, gnt0InN, strap, pciClk
`define PRGA_PINS          10

`endif

// [src/prga_pkg.sv]
// Types shared by the rotating group arbiter
package prga_pkg;
  typedef enum logic {PRGA_ARB, PRGA_BUSY} prga_state_type;
  typedef logic [2:0] prga_sel_type;
  typedef logic [4:0] prga_run_type;
endpackage

// [src/prga_arbiter.sv]
// Rotating three-tier bus arbiter with APB control registers
// Notes on behaviour
// - Arbitrate six requestors only as central resource
// - Highest tier rotates A, B, C; rest cyclic
// - Longest pending wins; empty tier falls lower
// - Tier A mask six bits, resets all allowed
// - Tier B, C masks same layout, reset empty
// - Tier A highest for run count, 0=16
// - Then other-tiers run, same encoding, reset one
// - Within others, B run then C run
// - B/C position survives interrupting tier A runs
// - Park in the current highest tier for that tier's hold clocks
// - Idle grant select when no requests, park expired
// - Idle grant leaves rotation state untouched
// - Disable bit hands over to external arbiter
`include "prga_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module prga_arbiter
  import prga_pkg::*;
#(
  parameter int AGE_W = 4
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // APB slave
  input  wire logic [`PRGA_ADDR_W-1:0]   paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Bus pins
  input  wire logic                      pciClk,
  input  wire logic [4:0]                reqN,
  input  wire logic                      frameN,
  input  wire logic                      irdyN,
  input  wire logic                      gnt0InN,
  input  wire logic                      centralResourceStrapN,
  output logic      [4:0]                gntOutN,
  output logic      [4:0]                gntOeN,
  output logic                           req0OutN,
  output logic                           req0OeN,
  // Own bus master
  input  wire logic                      ownReq,
  output logic                           ownGnt
);

  // Pin synchronisers: three stages, filtered value moves when stages two and three agree
  logic [`PRGA_PINS-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, pinsRaw;
  logic                  pciClkPrev_q;
  logic                  pciTick;

  assign pinsRaw = {pciClk, centralResourceStrapN, gnt0InN, irdyN, frameN, reqN};

  always_comb begin
    for (int i = 0; i < `PRGA_PINS; i++) begin
      filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q         <= {`PRGA_PINS{1'b1}};
      s2_q         <= {`PRGA_PINS{1'b1}};
      s3_q         <= {`PRGA_PINS{1'b1}};
      filt_q       <= {`PRGA_PINS{1'b1}};
      pciClkPrev_q <= 1'b1;
    end else begin
      s1_q         <= pinsRaw;
      s2_q         <= s1_q;
      s3_q         <= s2_q;
      filt_q       <= filt_d;
      pciClkPrev_q <= filt_q[9];
    end
  end

  // Rising edge of the sampled bus clock: every arbitration step runs on it
  assign pciTick = filt_q[9] & ~pciClkPrev_q;

  // Control register and APB slave
  logic [63:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_d, status;
  logic        pready_d, pslverr_d, hitLo, hitHi, hitSt;
  logic [63:0] wrBits, wrMask;

  assign hitLo = (paddr == `PRGA_OFS_CTRL_LO);
  assign hitHi = (paddr == `PRGA_OFS_CTRL_HI);
  assign hitSt = (paddr == `PRGA_OFS_STATUS);

  // Reads answer in the first access cycle; writes land on the completing edge
  always_comb begin
    pready_d  = psel & ~penable;
    pslverr_d = psel & ~penable & ~(hitLo | hitHi | (hitSt & ~pwrite));
    prdata_d  = 32'h0000_0000;
    if (psel & ~penable & ~pwrite) begin
      if (hitLo) begin
        prdata_d = ctrl_q[31:0];
      end else if (hitHi) begin
        prdata_d = ctrl_q[63:32];
      end else if (hitSt) begin
        prdata_d = status;
      end
    end
    wrMask = 64'h0;
    for (int b = 0; b < 4; b++) begin
      wrMask[b*8 +: 8]      = {8{pstrb[b] & hitLo}};
      wrMask[32 + b*8 +: 8] = {8{pstrb[b] & hitHi}};
    end
    wrMask = wrMask & `PRGA_CTRL_WMASK; // Reserved bits stay zero
    wrBits = {pwdata, pwdata};
    ctrl_d = ctrl_q;
    if (psel & penable & pwrite & pready & ~pslverr) begin
      ctrl_d = (ctrl_q & ~wrMask) | (wrBits & wrMask);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q  <= `PRGA_CTRL_RESET;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // Field views
  logic [5:0] tierMask [3];
  logic [3:0] holdClk  [3];
  logic [3:0] runA, runOn, runB, runC;
  logic [2:0] idleSel;
  logic       arbDisable, extMode;

  assign tierMask[0] = ctrl_q[`PRGA_F_TIER_A +: 6];
  assign tierMask[1] = ctrl_q[`PRGA_F_TIER_B +: 6];
  assign tierMask[2] = ctrl_q[`PRGA_F_TIER_C +: 6];
  assign holdClk[0]  = ctrl_q[`PRGA_F_HOLD_A +: 4];
  assign holdClk[1]  = ctrl_q[`PRGA_F_HOLD_B +: 4];
  assign holdClk[2]  = ctrl_q[`PRGA_F_HOLD_C +: 4];
  assign runA        = ctrl_q[`PRGA_F_RUN_A +: 4];
  assign runOn       = ctrl_q[`PRGA_F_RUN_ON +: 4];
  assign runB        = ctrl_q[`PRGA_F_RUN_B +: 4];
  assign runC        = ctrl_q[`PRGA_F_RUN_C +: 4];
  assign idleSel     = ctrl_q[`PRGA_F_IDLE_SEL +: 3];
  assign arbDisable  = ctrl_q[`PRGA_F_DISABLE];
  // Without the strap the part is a plain agent and always needs an outside arbiter
  assign extMode     = arbDisable | filt_q[8];

  // Run length of a field: zero stands for sixteen
  function automatic prga_run_type runLen(input logic [3:0] f);
    runLen = (f == 4'h0) ? 5'h10 : {1'b0, f};
  endfunction

  // Arbitration state
  prga_state_type              state_q, state_d;
  logic                        phaseA_q, phaseA_d, bcSel_q, bcSel_d;
  prga_run_type                cntA_q, cntA_d, cntOn_q, cntOn_d, cntBc_q, cntBc_d;
  logic [3:0]                  parkLeft_q, parkLeft_d;
  prga_sel_type                gntSel_q, gntSel_d;
  logic                        gntArb_q, gntArb_d;
  logic [AGE_W-1:0]            age_q [6];
  logic [AGE_W-1:0]            age_d [6];
  logic [5:0]                  reqs, cand;
  logic [1:0]                  hiTier, tier;
  prga_sel_type                winner;
  logic [AGE_W-1:0]            bestAge;
  logic                        accessStart;
  logic [4:0]                  gntOutN_d, gntOeN_d;
  logic                        req0OutN_d, req0OeN_d, ownGnt_d;

  assign reqs   = {ownReq, ~filt_q[4:0]};
  // Tier A leads during its run, else B or C by the alternation
  assign hiTier = phaseA_q ? 2'd0 : (bcSel_q ? 2'd2 : 2'd1);
  assign status = {16'h0000, 3'b000, extMode, parkLeft_q, gntSel_q,
                   state_q == PRGA_BUSY, phaseA_q, bcSel_q, hiTier};

  // Winner search: tiers from highest down, oldest requester within a tier
  always_comb begin
    winner  = `PRGA_SEL_NONE;
    bestAge = '0;
    cand    = 6'h00;
    tier    = hiTier;
    for (int k = 0; k < 3; k++) begin
      tier = 2'((32'(hiTier) + k) % 3);
      cand = reqs & tierMask[tier];
      if (parkLeft_q != 4'h0 && k != 0) begin
        cand = 6'h00;
      end
      if (winner == `PRGA_SEL_NONE) begin
        for (int i = 0; i < 6; i++) begin
          if (cand[i] && (winner == `PRGA_SEL_NONE || age_q[i] > bestAge)) begin
            winner  = 3'(i);
            bestAge = age_q[i];
          end
        end
      end
    end
  end

  // Bus start seen while in the arbitrate state, whatever grant stands
  assign accessStart = pciTick & ~extMode & (state_q == PRGA_ARB) & ~filt_q[5];

  always_comb begin
    state_d    = state_q;
    phaseA_d   = phaseA_q;
    bcSel_d    = bcSel_q;
    cntA_d     = cntA_q;
    cntOn_d    = cntOn_q;
    cntBc_d    = cntBc_q;
    parkLeft_d = parkLeft_q;
    gntSel_d   = gntSel_q;
    gntArb_d   = gntArb_q;
    for (int i = 0; i < 6; i++) begin
      age_d[i] = age_q[i];
      if (pciTick) begin
        if (!reqs[i]) begin
          age_d[i] = '0;
        end else if (age_q[i] != '1) begin
          age_d[i] = age_q[i] + 1'b1;
        end
      end
    end
    if (extMode) begin
      state_d    = PRGA_ARB;
      gntSel_d   = `PRGA_SEL_NONE;
      gntArb_d   = 1'b0;
      parkLeft_d = 4'h0;
    end else if (accessStart) begin
      state_d  = PRGA_BUSY;
      gntSel_d = `PRGA_SEL_NONE;
      gntArb_d = 1'b0;
      // Idle grants do not move the rotation
      if (gntArb_q && gntSel_q != `PRGA_SEL_NONE) begin
        age_d[gntSel_q] = '0;
        if (phaseA_q) begin
          if (cntA_q + 5'h01 >= runLen(runA)) begin
            phaseA_d = 1'b0;
            cntA_d   = 5'h00;
          end else begin
            cntA_d = cntA_q + 5'h01;
          end
        end else begin
          // The B/C counter is cleared only when its own run ends, not when tier A takes over, so it spans A runs
          if (cntBc_q + 5'h01 >= runLen(bcSel_q ? runC : runB)) begin
            bcSel_d = ~bcSel_q;
            cntBc_d = 5'h00;
          end else begin
            cntBc_d = cntBc_q + 5'h01;
          end
          if (cntOn_q + 5'h01 >= runLen(runOn)) begin
            phaseA_d = 1'b1;
            cntOn_d  = 5'h00;
          end else begin
            cntOn_d = cntOn_q + 5'h01;
          end
        end
      end
    end else if (pciTick && state_q == PRGA_BUSY) begin
      if (filt_q[5] && filt_q[6]) begin
        state_d    = PRGA_ARB;
        parkLeft_d = holdClk[hiTier];
      end
    end else if (pciTick) begin
      if (winner != `PRGA_SEL_NONE) begin
        gntSel_d = winner;
        gntArb_d = 1'b1;
      end else if (parkLeft_q != 4'h0) begin
        gntSel_d   = `PRGA_SEL_NONE;
        gntArb_d   = 1'b0;
        parkLeft_d = parkLeft_q - 4'h1;
      end else if (reqs[4:0] == 5'h00) begin
        gntSel_d = (idleSel > `PRGA_SEL_OWN) ? `PRGA_SEL_NONE : idleSel;
        gntArb_d = 1'b0;
      end else begin
        gntSel_d = `PRGA_SEL_NONE;
        gntArb_d = 1'b0;
      end
    end
  end

  // Pin drive: grant lines in arbiter mode, request/grant line 0 toward an outside arbiter
  always_comb begin
    gntOutN_d = 5'h1F;
    gntOeN_d  = 5'h1F;
    req0OutN_d = 1'b1;
    req0OeN_d  = 1'b1;
    ownGnt_d   = 1'b0;
    if (extMode) begin
      gntOeN_d[4:1] = 4'hF;
      req0OeN_d     = 1'b0;
      req0OutN_d    = ~ownReq;
      ownGnt_d      = ~filt_q[7];
    end else begin
      gntOeN_d = 5'h00;
      for (int i = 0; i < 5; i++) begin
        gntOutN_d[i] = ~(gntSel_q == 3'(i));
      end
      ownGnt_d = (gntSel_q == `PRGA_SEL_OWN);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q    <= PRGA_ARB;
      phaseA_q   <= 1'b1;
      bcSel_q    <= 1'b0;
      cntA_q     <= 5'h00;
      cntOn_q    <= 5'h00;
      cntBc_q    <= 5'h00;
      parkLeft_q <= 4'h0;
      gntSel_q   <= `PRGA_SEL_NONE;
      gntArb_q   <= 1'b0;
      for (int i = 0; i < 6; i++) begin
        age_q[i] <= '0;
      end
      gntOutN    <= 5'h1F;
      gntOeN     <= 5'h1F;
      req0OutN   <= 1'b1;
      req0OeN    <= 1'b1;
      ownGnt     <= 1'b0;
    end else begin
      state_q    <= state_d;
      phaseA_q   <= phaseA_d;
      bcSel_q    <= bcSel_d;
      cntA_q     <= cntA_d;
      cntOn_q    <= cntOn_d;
      cntBc_q    <= cntBc_d;
      parkLeft_q <= parkLeft_d;
      gntSel_q   <= gntSel_d;
      gntArb_q   <= gntArb_d;
      for (int i = 0; i < 6; i++) begin
        age_q[i] <= age_d[i];
      end
      gntOutN    <= gntOutN_d;
      gntOeN     <= gntOeN_d;
      req0OutN   <= req0OutN_d;
      req0OeN    <= req0OeN_d;
      ownGnt     <= ownGnt_d;
    end
  end

endmodule // prga_arbiter

`default_nettype wire

// [test/prga_arbiter_asserts.sv]
// Port-level assertions for the rotating group arbiter
`timescale 1ns/1ns
`default_nettype none
module prga_arbiter_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register bus
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  // Bus pins and own master
  input wire logic [4:0]  reqN,
  input wire logic        centralResourceStrapN,
  input wire logic        ownReq,
  input wire logic [4:0]  gntOutN,
  input wire logic [4:0]  gntOeN,
  input wire logic        req0OutN,
  input wire logic        req0OeN,
  input wire logic        ownGnt
);
  logic            disQ, disD;
  logic [4:0]      reqQ, ageQ, ageD;
  wire logic [4:0] grantN = gntOutN | gntOeN; // Undriven lines read as idle
  wire logic       extMode = centralResourceStrapN || disQ;
  // Shadow of the disable bit; age of the request pattern, saturating
  always_comb begin
    disD = disQ;
    if (psel && penable && pready && pwrite && paddr == 12'h004 && pstrb[3])
      disD = pwdata[31];
    ageD = (reqN != reqQ) ? 5'h00 : ageQ + {4'h0, ageQ != 5'h1F};
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      disQ <= 1'b0;
      reqQ <= 5'h1F;
      ageQ <= 5'h00;
    end else begin
      disQ <= disD;
      reqQ <= reqN;
      ageQ <= ageD;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  one_grant_a: assert property ($onehot0({~grantN, ownGnt}))
    else $error("two grants at once");
  ext_release_a: assert property (extMode [*8] |-> gntOeN == 5'h1F && !req0OeN)
    else $error("outside mode still granting");
  ext_req_a: assert property (extMode [*8] ##0 $stable(ownReq) |-> req0OutN == !ownReq)
    else $error("outside request wrong");
  arb_quiet_a: assert property (!extMode [*8] |-> req0OeN)
    else $error("request pin driven as arbiter");
  idle_only_a: assert property (
    ageQ >= 5'd24 && grantN != 5'h1F && (~grantN & ~reqN) == 5'h00 |-> reqN == 5'h1F)
    else $error("idle grant while requests pending");
endmodule // prga_arbiter_asserts
bind prga_arbiter prga_arbiter_asserts chk_inst (.clk, .reset, .paddr, .psel, .penable,
  .pwrite, .pwdata, .pstrb, .pready, .pslverr, .reqN, .centralResourceStrapN, .ownReq,
  .gntOutN, .gntOeN, .req0OutN, .req0OeN, .ownGnt);
`default_nettype wire

// [test/prga_pci_agents.sv]
// Five outside bus masters and the free-running bus clock
`timescale 1ns/1ns
`default_nettype none
module prga_pci_agents (
  // Requests wanted by the bench
  input  wire logic [4:0] want,
  // Grant pins from the arbiter
  input  wire logic [4:0] gntOutN,
  input  wire logic [4:0] gntOeN,
  // Bus pins toward the arbiter
  output logic            pciClk,
  output logic [4:0]      reqN,
  output logic            frameN,
  output logic            irdyN,
  // Transfer log
  output logic [2:0]      lastWin,
  output int              wins
);
  logic            found;
  logic [1:0]      phase;
  wire logic [4:0] seenN = gntOutN | gntOeN; // Pull-ups hold undriven grants high
  // Bus clock runs free; its edges stay off the system clock edges so pin sampling never races
  initial begin
    {pciClk, reqN, frameN, irdyN, phase, lastWin, wins} = {1'b0, 5'h1F, 2'b11, 5'h00, 32'd0};
    #2;
    forever begin
      #62 pciClk = 1'b1;
      #63 pciClk = 1'b0;
    end
  end
  // One single-data-phase transfer per grant, only on an idle bus
  always @(posedge pciClk) begin
    found = 1'b0;
    case (phase)
      2'd0: begin
        reqN <= ~want;
        for (int i = 0; i < 5; i++) begin
          if (!found && want[i] && !seenN[i] && frameN && irdyN) begin
            found = 1'b1;
            lastWin <= 3'(i);
            reqN[i] <= 1'b1;
            frameN <= 1'b0;
            irdyN <= 1'b0;
            phase <= 2'd1;
          end
        end
      end
      2'd1: begin
        frameN <= 1'b1;
        phase <= 2'd2;
      end
      default: begin
        irdyN <= 1'b1;
        wins <= wins + 1;
        phase <= 2'd0;
      end
    endcase
  end
endmodule // prga_pci_agents
`default_nettype wire

// [test/prga_arbiter_test.sv]
// Self-checking bench for the rotating group arbiter
`timescale 1ns/1ns
`default_nettype none
`include "prga_cfg.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module prga_arbiter_test;
  logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        gnt0InN = 1'b1, strapN = 1'b1, ownReq = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [4:0]  want = 5'h00, reqN, gntOutN, gntOeN;
  logic        pready, pslverr, pciClk, frameN, irdyN, req0OutN, req0OeN, ownGnt;
  logic [2:0]  lastWin;
  int          wins, seedv, compares = 0, miscompares = 0, cycles = 0;
  int          t0, t1;
  logic [3:0]  hold;
  prga_arbiter prga_arbiter_inst (.clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .pciClk, .reqN, .frameN, .irdyN, .gnt0InN,
    .centralResourceStrapN(strapN), .gntOutN, .gntOeN, .req0OutN, .req0OeN, .ownReq, .ownGnt);
  prga_pci_agents prga_pci_agents_inst (.want, .gntOutN, .gntOeN, .pciClk, .reqN, .frameN,
    .irdyN, .lastWin, .wins);
  always #5 clk = ~clk;
  // Hang guard; the whole run needs about 4200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic doReset();
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
  endtask
  // One bus transfer; waits for ready rather than assuming a latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      miscompares++;
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Highest tier of access n, agent i sitting alone in tier i
  function automatic int tierAt(int n, logic [3:0] ra, ro, rb, rc);
    int a = 0, o = 0, b = 0, bc = 0, t = 0, inA = 1;
    int len [4];
    len = '{ra, ro, rb, rc};
    foreach (len[i]) if (len[i] == 0) len[i] = 16;
    for (int i = 0; i <= n; i++) begin
      t = inA ? 0 : 1 + bc;
      if (inA) begin
        a++;
        if (a == len[0]) begin
          inA = 0;
          a = 0;
        end
      end else begin
        o++;
        b++;
        if (b == len[2 + bc]) begin
          bc = 1 - bc;
          b = 0;
        end
        if (o == len[1]) begin
          inA = 1;
          o = 0;
        end
      end
    end
    return t;
  endfunction
  // Waits for the next finished transfer; a hang counts as a mismatch
  task automatic waitWin();
    int seen = wins, t = 0;
    while (wins == seen && t < 400) begin
      @(posedge clk);
      t++;
    end
    if (t >= 400)
      miscompares++;
  endtask
  // Bus clock edges from the end of a tier A access to the next tier B transfer
  task automatic parkRun(input logic [3:0] hd, output int ticks);
    int seen;
    apb(1'b1, `PRGA_OFS_CTRL_HI, {16'h0070, 4'h0, hd, 8'h11});
    want <= 5'h01;
    waitWin();
    want <= 5'h02;
    seen = wins;
    ticks = 0;
    while (wins == seen && ticks < 40) begin
      @(posedge pciClk);
      ticks++;
    end
    if (ticks >= 40)
      miscompares++;
    want <= 5'h00;
    repeat (80) @(posedge clk);
  endtask
  task automatic runCfg(input logic [3:0] ra, ro, rb, rc);
    apb(1'b1, `PRGA_OFS_CTRL_LO, {ro, ra, 24'h04_02_01});
    apb(1'b1, `PRGA_OFS_CTRL_HI, {16'h0070, 8'h00, rc, rb});
    want <= 5'h07;
    for (int n = 0; n < 20; n++) begin
      waitWin();
      `CHK("winner", 3'(tierAt(n, ra, ro, rb, rc)), lastWin)
    end
    want <= 5'h00;
    repeat (80) @(posedge clk);
  endtask
  initial begin
    seedv = $urandom(98219);
    doReset();
    repeat (12) @(posedge clk);
    strapN <= 1'b0;
    repeat (8) @(posedge clk);
    apb(1'b0, `PRGA_OFS_CTRL_LO, 32'h0);
    `CHK("ctrl low", 32'h1100_003F, rd)
    apb(1'b0, `PRGA_OFS_CTRL_HI, 32'h0);
    `CHK("ctrl high", 32'h0050_0011, rd)
    apb(1'b1, `PRGA_OFS_STATUS, 32'hFFFF_FFFF);
    `CHK("status write", 1'b1, er)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {er, rd})
    for (int i = 0; i < 2; i++) begin
      seedv = $urandom;
      apb(1'b1, 12'(i * 4), seedv);
      apb(1'b0, 12'(i * 4), 32'h0);
      `CHK("readback", seedv & (i ? 32'h807F_FFFF : 32'hFF3F_3F3F), rd)
    end
    $display("test registers done");
    apb(1'b1, `PRGA_OFS_CTRL_LO, 32'h1100_003F);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `PRGA_OFS_CTRL_HI, 32'h0000_0011 | (c << 20));
      repeat (40) @(posedge clk);
      `CHK("idle grant", (c < 5) ? ~(5'h01 << c) : 5'h1F, gntOutN | gntOeN)
      `CHK("idle own grant", c == 5, ownGnt)
    end
    $display("test idle grant done");
    // Idle grants above must not have moved the rotation
    runCfg(4'h2, 4'h3, 4'h2, 4'h2);
    doReset();
    runCfg(4'h0, 4'h1, 4'h1, 4'h1);
    doReset();
    runCfg(4'($urandom), 4'($urandom), 4'($urandom), 4'($urandom));
    $display("test rotation done");
    // Agent 0 alone in tier A, agent 1 in tier B; the park hold delays agent 1 by its count
    doReset();
    apb(1'b1, `PRGA_OFS_CTRL_LO, 32'h1000_0201);
    hold = 4'(1 + $urandom % 15);
    parkRun(4'h0, t0);
    parkRun(hold, t1);
    `CHK("park delay", 32'(hold), t1 - t0)
    $display("test park done");
    apb(1'b1, `PRGA_OFS_CTRL_HI, 32'h8070_0011);
    ownReq <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("outside request", 3'b000, {req0OutN, req0OeN, ownGnt})
    `CHK("grants released", 5'h1F, gntOeN)
    gnt0InN <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("outside grant", 1'b1, ownGnt)
    {ownReq, gnt0InN} <= 2'b01;
    repeat (8) @(posedge clk);
    `CHK("request dropped", 2'b10, {req0OutN, ownGnt})
    $display("test outside arbiter done");
    summarize();
  end
endmodule // prga_arbiter_test
`default_nettype wire
